// file: design/crg_params.svh
// Constants for the core register set and address generation block
`ifndef CRG_PARAMS_SVH
`define CRG_PARAMS_SVH
`define CRG_CODE_SEG_RST   16'hffff
`define CRG_ZERO_SEG_RST   16'h0000
`define CRG_OFFSET_RST     16'h0000
`define CRG_STATUS_RST     16'hf000
`define CRG_SEG_SHIFT      4
`define CRG_QUEUE_DEPTH    6
`define CRG_WIDE_BUS       1
`endif

// file: design/crg_pkg.sv
// Types for the core register set and address generation block
package crg_pkg;
  // General register selector: four data words then pointers and indexes
  typedef enum logic [2:0] {
    CRG_R_ACC, CRG_R_CNT, CRG_R_PORT, CRG_R_BASE,
    CRG_R_STK, CRG_R_FRM, CRG_R_SRC, CRG_R_DST
  } crg_reg_t;
  // Segment selector
  typedef enum logic [1:0] {
    CRG_S_EXTRA, CRG_S_CODE, CRG_S_STACK, CRG_S_DATA
  } crg_seg_t;
  // Register write request from the execute unit
  typedef struct packed {
    logic        we;
    logic        byte_op;
    logic        high;
    crg_reg_t    sel;
    logic [15:0] data;
  } crg_gwr_t;
  // Operand access request from the execute unit
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        io;
    logic        word;
    crg_seg_t    seg;
    logic [15:0] offset;
    logic [15:0] data;
  } crg_acc_t;
  // Arithmetic request
  typedef struct packed {
    logic        byte_op;
    logic [2:0]  op;
    logic [15:0] a;
    logic [15:0] b;
  } crg_alu_t;
endpackage : crg_pkg

// file: design/crg_core.sv
// Register set, address adder and prefetch coupling of a 16-bit core
`timescale 1ns/1ns
`include "crg_params.svh"
module crg_core #(
  parameter int WIDE_BUS    = `CRG_WIDE_BUS,
  parameter int QUEUE_DEPTH = `CRG_QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Execute unit: opcode byte take
  input  wire logic              op_take_i,
  output logic                   op_valid_o,
  output logic [7:0]             op_byte_o,
  // Execute unit: register file
  input  wire crg_pkg::crg_gwr_t gwr_i,
  input  wire crg_pkg::crg_reg_t rd_sel_i,
  input  wire logic              rd_byte_i,
  input  wire logic              rd_high_i,
  output logic [15:0]            rd_data_o,
  output logic [7:0]             shift_count_byte_o,
  // Execute unit: segment and status writes, control transfer
  input  wire logic              seg_we_i,
  input  wire crg_pkg::crg_seg_t seg_sel_i,
  input  wire logic [15:0]       seg_data_i,
  input  wire logic              status_we_i,
  input  wire logic [15:0]       status_data_i,
  input  wire logic              jump_i,
  input  wire logic [15:0]       jump_offset_i,
  output logic [15:0]            status_o,
  output logic [15:0]            next_fetch_offset_o,
  // Execute unit: arithmetic
  input  wire crg_pkg::crg_alu_t alu_i,
  output logic [15:0]            alu_res_o,
  // Execute unit: operand access
  input  wire crg_pkg::crg_acc_t acc_i,
  output logic                   acc_busy_o,
  output logic                   acc_done_o,
  output logic [15:0]            acc_rdata_o,
  // External bus
  output logic                   bus_req_o,
  output logic                   bus_wr_o,
  output logic                   bus_io_o,
  output logic [19:0]            bus_addr_o,
  output logic [15:0]            bus_wdata_o,
  output logic [1:0]             bus_be_o,
  input  wire logic              bus_ack_i,
  input  wire logic [15:0]       bus_rdata_i
);
  import crg_pkg::*;

  localparam int BW = (WIDE_BUS != 0) ? 2 : 1;
  localparam int PW = $clog2(QUEUE_DEPTH + 1);

  // Physical address: segment shifted left four plus offset, carry dropped
  function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = ({seg, 4'h0} + {4'h0, off});
  endfunction : phys

  // Register state
  logic [15:0] gen_q [8];
  logic [15:0] seg_q [4];
  logic [15:0] fetch_off_q;
  logic [15:0] status_q;
  logic [7:0]  queue_q [QUEUE_DEPTH];
  logic [PW-1:0] count_q;
  logic        flush_q;

  // Bus sequencer
  typedef enum logic [1:0] { CRG_IDLE, CRG_FETCH, CRG_OPER, CRG_OPER2 } crg_bus_st_t;
  crg_bus_st_t st_q;
  logic        oper_word_q;
  logic [15:0] oper_off_q;
  crg_seg_t    oper_seg_q;
  logic        oper_wr_q;
  logic        oper_io_q;
  logic [15:0] oper_data_q;

  // General register writes; no reset so contents are undefined
  always_ff @(posedge clk_sys_i)
  begin
    if (gwr_i.we)
    begin
      if (gwr_i.byte_op && gwr_i.sel <= CRG_R_BASE)
      begin
        if (gwr_i.high)
          gen_q[gwr_i.sel][15:8] <= gwr_i.data[7:0];
        else
          gen_q[gwr_i.sel][7:0] <= gwr_i.data[7:0];
      end
      else
        gen_q[gwr_i.sel] <= gwr_i.data;
    end
  end

  // Register reads: byte halves only for data registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rd_data_o <= 16'h0000;
    else if (rd_byte_i && rd_sel_i <= CRG_R_BASE)
      rd_data_o <= {8'h00, rd_high_i ? gen_q[rd_sel_i][15:8] : gen_q[rd_sel_i][7:0]};
    else
      rd_data_o <= gen_q[rd_sel_i];
  end

  // Implicit shift count
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      shift_count_byte_o <= 8'h00;
    else
      shift_count_byte_o <= gen_q[CRG_R_CNT][7:0];
  end

  // Arithmetic unit, byte or word width
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      alu_res_o <= 16'h0000;
    else
    begin
      logic [15:0] r;
      r = 16'h0000;
      case (alu_i.op)
        3'h0:    r = alu_i.a + alu_i.b;
        3'h1:    r = alu_i.a - alu_i.b;
        3'h2:    r = alu_i.a & alu_i.b;
        3'h3:    r = alu_i.a | alu_i.b;
        3'h4:    r = alu_i.a ^ alu_i.b;
        3'h5:    r = alu_i.a << gen_q[CRG_R_CNT][7:0];
        3'h6:    r = alu_i.a >> gen_q[CRG_R_CNT][7:0];
        default: r = alu_i.a;
      endcase
      alu_res_o <= alu_i.byte_op ? {8'h00, r[7:0]} : r;
    end
  end

  // Segment registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      seg_q[CRG_S_CODE]  <= `CRG_CODE_SEG_RST;
      seg_q[CRG_S_DATA]  <= `CRG_ZERO_SEG_RST;
      seg_q[CRG_S_EXTRA] <= `CRG_ZERO_SEG_RST;
      seg_q[CRG_S_STACK] <= `CRG_ZERO_SEG_RST;
    end
    else if (seg_we_i)
      seg_q[seg_sel_i] <= seg_data_i;
  end

  // Status word
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      status_q <= `CRG_STATUS_RST;
    else if (status_we_i)
      status_q <= status_data_i;
  end
  assign status_o = status_q;

  // Flush request on control transfer or code segment change
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flush_q <= 1'b0;
    else
      flush_q <= jump_i || (seg_we_i && seg_sel_i == CRG_S_CODE);
  end

  // Bus sequencer: operands take priority, otherwise prefetch
  logic fetch_ok;
  logic [PW-1:0] room;
  assign room = PW'(QUEUE_DEPTH) - count_q;
  assign fetch_ok = !flush_q && !jump_i && room >= PW'(BW);
  // A fetch lands only if no flush hit it while it was in flight
  logic fetch_land;
  logic stale_q;
  logic [15:0] fetch_off_d;
  assign fetch_land  = st_q == CRG_FETCH && bus_ack_i && !flush_q && !jump_i && !stale_q;
  assign fetch_off_d = fetch_land ? fetch_off_q + 16'(BW) : fetch_off_q;
  // Fetch caught by a flush returns bytes from the old address: drop them
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || (st_q == CRG_FETCH && bus_ack_i))
      stale_q <= 1'b0;
    else if (st_q == CRG_FETCH && (jump_i || flush_q))
      stale_q <= 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_q        <= CRG_IDLE;
      bus_req_o   <= 1'b0;
      bus_wr_o    <= 1'b0;
      bus_io_o    <= 1'b0;
      bus_addr_o  <= 20'h00000;
      bus_wdata_o <= 16'h0000;
      bus_be_o    <= 2'h0;
      acc_busy_o  <= 1'b0;
      acc_done_o  <= 1'b0;
      acc_rdata_o <= 16'h0000;
      oper_word_q <= 1'b0;
      oper_off_q  <= 16'h0000;
      oper_seg_q  <= CRG_S_DATA;
      oper_wr_q   <= 1'b0;
      oper_io_q   <= 1'b0;
      oper_data_q <= 16'h0000;
    end
    else
    begin
      acc_done_o <= 1'b0;
      case (st_q)
        CRG_IDLE:
        begin
          if (acc_i.req)
          begin
            st_q        <= CRG_OPER;
            acc_busy_o  <= 1'b1;
            oper_word_q <= acc_i.word;
            oper_off_q  <= acc_i.offset;
            oper_seg_q  <= acc_i.seg;
            oper_wr_q   <= acc_i.wr;
            oper_io_q   <= acc_i.io;
            oper_data_q <= acc_i.data;
            bus_req_o   <= 1'b1;
            bus_wr_o    <= acc_i.wr;
            bus_io_o    <= acc_i.io;
            bus_addr_o  <= acc_i.io ? {4'h0, acc_i.offset} : phys(seg_q[acc_i.seg], acc_i.offset);
            bus_wdata_o <= acc_i.data;
            bus_be_o    <= (BW == 2 && acc_i.word) ? 2'h3 : 2'h1;
          end
          else if (fetch_ok)
          begin
            st_q       <= CRG_FETCH;
            bus_req_o  <= 1'b1;
            bus_wr_o   <= 1'b0;
            bus_io_o   <= 1'b0;
            bus_addr_o <= phys(seg_q[CRG_S_CODE], fetch_off_q);
            bus_be_o   <= (BW == 2) ? 2'h3 : 2'h1;
          end
        end
        CRG_FETCH:
        begin
          if (bus_ack_i)
          begin
            st_q      <= CRG_IDLE;
            bus_req_o <= 1'b0;
          end
        end
        CRG_OPER:
        begin
          if (bus_ack_i)
          begin
            acc_rdata_o <= bus_rdata_i;
            if (BW == 1 && oper_word_q) // Narrow bus: second byte cycle
            begin
              st_q        <= CRG_OPER2;
              bus_addr_o  <= oper_io_q ? {4'h0, oper_off_q + 16'h0001}
                                       : phys(seg_q[oper_seg_q], oper_off_q + 16'h0001);
              bus_wdata_o <= {8'h00, oper_data_q[15:8]};
            end
            else
            begin
              st_q       <= CRG_IDLE;
              bus_req_o  <= 1'b0;
              acc_busy_o <= 1'b0;
              acc_done_o <= 1'b1;
            end
          end
        end
        CRG_OPER2:
        begin
          if (bus_ack_i)
          begin
            acc_rdata_o <= {bus_rdata_i[7:0], acc_rdata_o[7:0]};
            st_q        <= CRG_IDLE;
            bus_req_o   <= 1'b0;
            acc_busy_o  <= 1'b0;
            acc_done_o  <= 1'b1;
          end
        end
        default: st_q <= CRG_IDLE;
      endcase
    end
  end

  // Fetch offset: advance per fetched unit, load on control transfer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      fetch_off_q <= `CRG_OFFSET_RST;
    else if (jump_i)
      fetch_off_q <= jump_offset_i;
    else
      fetch_off_q <= fetch_off_d;
  end
  assign next_fetch_offset_o = fetch_off_q;

  // Prefetch queue: shift out at the head, append fetched bytes
  logic take;
  logic put;
  assign take = op_take_i && count_q != '0;
  assign put  = fetch_land;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || jump_i || flush_q)
      count_q <= '0;
    else
    begin
      logic [PW-1:0] c;
      c = count_q;
      if (take)
      begin
        for (int i = 0; i < QUEUE_DEPTH - 1; i++)
          queue_q[i] <= queue_q[i + 1];
        c = c - PW'(1);
      end
      if (put)
      begin
        queue_q[c] <= bus_rdata_i[7:0];
        if (BW == 2)
          queue_q[c + PW'(1)] <= bus_rdata_i[15:8];
        c = c + PW'(BW);
      end
      count_q <= c;
    end
  end

  // Opcode byte presented to the execute unit
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      op_valid_o <= 1'b0;
      op_byte_o  <= 8'h00;
    end
    else
    begin
      op_valid_o <= (count_q - (take ? PW'(1) : PW'(0))) != '0 && !jump_i && !flush_q;
      op_byte_o  <= take ? queue_q[1] : queue_q[0];
    end
  end
endmodule : crg_core

// file: verification/crg_core_chk.sv
// Port checker for the core register and address block
`timescale 1ns/1ns
module crg_core_chk #(
  parameter int WIDE_BUS = 1
) (
  // Clock and reset
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  // Execute side
  input wire crg_pkg::crg_gwr_t gwr_i,
  input wire crg_pkg::crg_alu_t alu_i,
  input wire logic [15:0]       alu_res_o,
  input wire logic [7:0]        shift_count_byte_o,
  input wire logic [15:0]       status_o,
  input wire logic [15:0]       next_fetch_offset_o,
  input wire logic              acc_busy_o,
  input wire logic              acc_done_o,
  // External bus
  input wire logic              bus_req_o,
  input wire logic              bus_io_o,
  input wire logic [19:0]       bus_addr_o,
  input wire logic [15:0]       bus_wdata_o,
  input wire logic              bus_ack_i
);
  import crg_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Reset values
  a_status_reset: assert property ($fell(rst_i) |-> status_o == 16'hf000)
    else $error("status word wrong after reset");
  a_offset_reset: assert property ($fell(rst_i) |-> next_fetch_offset_o == 16'h0000)
    else $error("fetch offset not zero after reset");
  a_first_fetch: assert property ($fell(rst_i) |-> ##[1:8] (bus_req_o && bus_addr_o == 20'hffff0))
    else $error("first fetch not at ffff0");
  // Bus cycle discipline
  a_bus_hold: assert property (bus_req_o && !bus_ack_i |=>
    bus_req_o && $stable(bus_addr_o) && $stable(bus_wdata_o))
    else $error("bus cycle changed before ack");
  a_req_gap: assert property (bus_req_o && bus_ack_i |=>
    !bus_req_o || (WIDE_BUS == 0 && acc_busy_o))
    else $error("no idle cycle after ack");
  a_done_pulse: assert property (WIDE_BUS == 1 && acc_busy_o && bus_ack_i |=>
    acc_done_o ##1 !acc_done_o)
    else $error("operand done pulse wrong");
  a_io_high: assert property (bus_req_o && bus_io_o |-> bus_addr_o[19:16] == 4'h0)
    else $error("io address above sixteen bits");
  // Execute side results
  a_shift_count: assert property (gwr_i.we && gwr_i.sel == CRG_R_CNT && !gwr_i.byte_op
    ##1 !gwr_i.we |=> shift_count_byte_o == $past(gwr_i.data[7:0], 2))
    else $error("shift count byte not count low byte");
  a_alu_add: assert property (alu_i.op == 3'h0 && !alu_i.byte_op |=>
    alu_res_o == 16'($past(alu_i.a) + $past(alu_i.b)))
    else $error("word add result wrong");
endmodule : crg_core_chk

bind crg_core crg_core_chk #(.WIDE_BUS(WIDE_BUS)) crg_core_chk_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .gwr_i(gwr_i), .alu_i(alu_i),
  .alu_res_o(alu_res_o), .shift_count_byte_o(shift_count_byte_o), .status_o(status_o),
  .next_fetch_offset_o(next_fetch_offset_o), .acc_busy_o(acc_busy_o),
  .acc_done_o(acc_done_o), .bus_req_o(bus_req_o), .bus_io_o(bus_io_o),
  .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_ack_i(bus_ack_i));

// file: verification/crg_mem_model.sv
// Memory and peripheral model on the external bus
`timescale 1ns/1ns
module crg_mem_model (
  // Clock, reset and pace
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  // Bus
  input  wire logic        bus_req_i,
  input  wire logic [19:0] bus_addr_i,
  output logic             bus_ack_o,
  output logic [15:0]      bus_rdata_o
);
  logic [1:0] wait_q;
  // Ack once per cycle, bytes equal low address bits, data garbled when idle
  always_ff @(posedge clk_sys_i)
  begin
    bus_ack_o   <= 1'b0;
    bus_rdata_o <= rst_i ? 16'h0000 : ~bus_rdata_o;
    if (rst_i || !bus_req_i || bus_ack_o)
      wait_q <= 2'h0;
    else if (wait_q < {slow_i, slow_i})
      wait_q <= wait_q + 2'h1;
    else
    begin
      bus_ack_o   <= 1'b1;
      bus_rdata_o <= {bus_addr_i[7:0] + 8'h01, bus_addr_i[7:0]};
    end
  end
endmodule : crg_mem_model

// file: verification/test_crg_core.sv
// Self-checking bench for the core register and address block
`timescale 1ns/1ns
module test_crg_core;
  import crg_pkg::*;
  logic        clk_sys_i, rst_i, op_take_i, rd_byte_i, rd_high_i, seg_we_i, jump_i;
  logic        slow, bus_ack_i, op_valid_o, acc_busy_o, acc_done_o, bus_req_o;
  logic        bus_wr_o, bus_io_o;
  logic [7:0]  op_byte_o, shift_count_byte_o;
  logic [15:0] seg_data_i, jump_offset_i, bus_rdata_i, rd_data_o, status_o, acc_wdata;
  logic [15:0] next_fetch_offset_o, alu_res_o, acc_rdata_o, bus_wdata_o;
  logic [19:0] bus_addr_o, acc_addr;
  logic [1:0]  bus_be_o;
  logic [3:0]  acc_ctl;
  crg_gwr_t    gwr_i;
  crg_reg_t    rd_sel_i;
  crg_seg_t    seg_sel_i;
  crg_alu_t    alu_i;
  crg_acc_t    acc_i;
  int          n_fail, check_count;

  crg_core #(.WIDE_BUS(1), .QUEUE_DEPTH(6)) crg_core_i (.clk_sys_i, .rst_i, .op_take_i,
    .op_valid_o, .op_byte_o, .gwr_i, .rd_sel_i, .rd_byte_i, .rd_high_i, .rd_data_o,
    .shift_count_byte_o, .seg_we_i, .seg_sel_i, .seg_data_i, .status_we_i(1'b0),
    .status_data_i(16'h0000), .jump_i, .jump_offset_i, .status_o, .next_fetch_offset_o,
    .alu_i, .alu_res_o, .acc_i, .acc_busy_o, .acc_done_o, .acc_rdata_o, .bus_req_o,
    .bus_wr_o, .bus_io_o, .bus_addr_o, .bus_wdata_o, .bus_be_o, .bus_ack_i, .bus_rdata_i);
  crg_mem_model crg_mem_model_i (.clk_sys_i, .rst_i, .slow_i(slow), .bus_req_i(bus_req_o),
    .bus_addr_i(bus_addr_o), .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i));

  // Clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Record operand bus cycles
  always @(posedge clk_sys_i)
    if (bus_req_o && acc_busy_o)
    begin
      acc_addr  <= bus_addr_o;
      acc_wdata <= bus_wdata_o;
      acc_ctl   <= {bus_io_o, bus_wr_o, bus_be_o};
    end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (s !== 1'b1 && n < 300);
  endtask : wait_hi
  task automatic take(input logic [7:0] e);
    wait_hi(op_valid_o);
    chk(op_byte_o, e);
    @(posedge clk_sys_i);
    op_take_i <= 1'b1;
    @(posedge clk_sys_i);
    op_take_i <= 1'b0;
    tick(1);
  endtask : take
  task automatic wr(input crg_reg_t s, input logic b, h, input logic [15:0] d);
    @(posedge clk_sys_i);
    gwr_i <= '{we: 1'b1, byte_op: b, high: h, sel: s, data: d};
    @(posedge clk_sys_i);
    gwr_i.we <= 1'b0;
  endtask : wr
  task automatic rd(input crg_reg_t s, input logic b, h, input logic [15:0] e);
    @(posedge clk_sys_i);
    rd_sel_i  <= s;
    rd_byte_i <= b;
    rd_high_i <= h;
    tick(1);
    chk(rd_data_o, e);
  endtask : rd
  task automatic alu(input logic b, input logic [2:0] o, input logic [15:0] x, y, e);
    @(posedge clk_sys_i);
    alu_i <= '{byte_op: b, op: o, a: x, b: y};
    tick(1);
    chk(alu_res_o, e);
  endtask : alu
  task automatic seg(input crg_seg_t s, input logic [15:0] d);
    @(posedge clk_sys_i);
    seg_we_i   <= 1'b1;
    seg_sel_i  <= s;
    seg_data_i <= d;
    @(posedge clk_sys_i);
    seg_we_i <= 1'b0;
  endtask : seg
  task automatic acc(input crg_seg_t s, input logic w, io, input logic [15:0] o, d,
                     input logic [19:0] ea, input logic [15:0] e);
    @(posedge clk_sys_i);
    acc_i <= '{req: 1'b1, wr: w, io: io, word: 1'b1, seg: s, offset: o, data: d};
    wait_hi(acc_busy_o);
    @(posedge clk_sys_i);
    acc_i.req <= 1'b0;
    wait_hi(acc_done_o);
    chk(acc_addr, ea);
    chk(w ? acc_wdata : acc_rdata_o, e);
    chk({16'h0000, acc_ctl}, {16'h0000, io, w, 2'h3});
  endtask : acc

  task automatic t_fetch;
    chk(status_o, 16'hf000);
    chk(next_fetch_offset_o, 16'h0000);
    for (int i = 0; i < 10; i++)
      take(8'hf0 + 8'(i));
    $display("test fetch done");
  endtask : t_fetch
  task automatic t_jump;
    @(posedge clk_sys_i);
    jump_offset_i <= 16'h0020;
    jump_i        <= 1'b1;
    @(posedge clk_sys_i);
    jump_i <= 1'b0;
    tick(3);
    take(8'h10);
    take(8'h11);
    $display("test jump done");
  endtask : t_jump
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      wr(crg_reg_t'(i), 1'b0, 1'b0, 16'h1111 * 16'(i + 1));
    for (int i = 0; i < 8; i++)
      rd(crg_reg_t'(i), 1'b0, 1'b0, 16'h1111 * 16'(i + 1));
    chk(shift_count_byte_o, 8'h22);
    wr(CRG_R_PORT, 1'b1, 1'b1, 16'habab);
    rd(CRG_R_PORT, 1'b0, 1'b0, 16'hab33);
    rd(CRG_R_PORT, 1'b1, 1'b1, 16'h00ab);
    rd(CRG_R_PORT, 1'b1, 1'b0, 16'h0033);
    wr(CRG_R_DST, 1'b1, 1'b1, 16'h5678);
    rd(CRG_R_DST, 1'b1, 1'b0, 16'h5678);
    $display("test regs done");
  endtask : t_regs
  task automatic t_alu;
    alu(1'b0, 3'h0, 16'hffff, 16'h0002, 16'h0001);
    alu(1'b1, 3'h0, 16'h12ff, 16'h0001, 16'h0000);
    alu(1'b1, 3'h1, 16'h0010, 16'h0011, 16'h00ff);
    alu(1'b0, 3'h5, 16'h0001, 16'h0000, 16'h0000);
    wr(CRG_R_CNT, 1'b1, 1'b0, 16'h0003);
    alu(1'b0, 3'h5, 16'h0001, 16'h0000, 16'h0008);
    alu(1'b0, 3'h6, 16'h0100, 16'h0000, 16'h0020);
    $display("test alu done");
  endtask : t_alu
  task automatic t_acc;
    slow <= 1'b0;
    acc(CRG_S_EXTRA, 1'b0, 1'b0, 16'h0100, 16'h0000, 20'h00100, 16'h0100);
    seg(CRG_S_DATA, 16'h1234);
    seg(CRG_S_STACK, 16'hffff);
    acc(CRG_S_DATA, 1'b0, 1'b0, 16'h0010, 16'h0000, 20'h12350, 16'h5150);
    acc(CRG_S_STACK, 1'b0, 1'b0, 16'hfffe, 16'h0000, 20'h0ffee, 16'hefee);
    acc(CRG_S_DATA, 1'b1, 1'b1, 16'h0040, 16'hbeef, 20'h00040, 16'hbeef);
    $display("test access done");
  endtask : t_acc
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    {op_take_i, rd_byte_i, rd_high_i, seg_we_i, jump_i} = '0;
    rst_i         = 1'b1;
    slow          = 1'b1;
    gwr_i         = '0;
    rd_sel_i      = CRG_R_ACC;
    seg_sel_i     = CRG_S_EXTRA;
    seg_data_i    = 16'h0000;
    jump_offset_i = 16'h0000;
    alu_i         = '0;
    acc_i         = '0;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    t_fetch();
    t_jump();
    t_regs();
    t_alu();
    t_acc();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    end_of_test();
  end
endmodule : test_crg_core
